// file: rtl/fcc_top.sv
// flash charge control: charge sequencing, completion flag, strobe gate
// assumes comparator outputs and host pins are asynchronous to clk
// assumes an external pull-up on the open-drain completion pin

// Operation
// RL1: charge starts only with request high, latched
// RL2: enable rises after deliberate noise-rejecting delay
// RL3: request low stops charging immediately
// RL4: full-charge detection stops charging
// RL5: overcurrent on switch stops charging
// RL6: restart after forced stop repeats delay
// RL7: done pin is open drain, low when full
// RL8: done pin released while charging or faulted
// RL9: done low until request goes low
// RL10: done falls shortly after full threshold
// RL11: switch off shortly after peak limit
// RL12: gate follows strobe inputs after short delay
// RL13: gate on only when both inputs high
// RL14: no done after trip while request high
// RL15: host times request-to-done to find trips
// RL16: completion clears enable, enters disabled mode
// RL17: trip latches off until request low, cleared
// RL18: request drop during delay abandons start
module fcc_top import fcc_pkg::*; #(
    parameter int unsigned ARM_CYC = FCC_EN_DLY_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic charge_request,
    input  wire logic full_detect,
    input  wire logic overcurrent_detect,
    input  wire logic thermal_detect,
    input  wire logic peak_detect,
    input  wire logic zero_detect,
    input  wire logic flash_fire,
    input  wire logic flash_permit,
    output logic      primary_switch,
    output logic      charge_enable_int,
    output logic      charge_done_n_o,
    output logic      charge_done_n_oe,
    output logic      gate_drive_out,
    output logic      fault_latched
);

    localparam logic [FCC_CNT_W-1:0] ARM_LAST = FCC_CNT_W'(ARM_CYC - 1);
    localparam int LAT = 3;

    typedef struct packed {
        logic [FCC_NSYNC-1:0] meta;
        logic [FCC_NSYNC-1:0] stab;
        logic [1:0]           fmeta;
        logic [1:0]           fstab;
        fcc_mode_t            mode;
        logic [FCC_CNT_W-1:0] cnt;
        logic                 sw;
    } fcc_top_st_t;

    fcc_top_st_t q;
    fcc_top_st_t d;

    logic [1:0] rst_pipe_q;
    logic       rst_sync_n;

    logic req;
    logic full;
    logic overcurrent_trip;
    logic tsd;
    logic peak;
    logic zc;

    fcc_if gif ();

    // ========================================================================
    // reset release
    // ========================================================================
    // release is synchronous so every state flop leaves reset together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe_q[1];

    // ========================================================================
    // synchronised inputs
    // ========================================================================
    assign req  = q.stab[FCC_S_REQ];
    assign full = q.stab[FCC_S_FUL];
    assign overcurrent_trip  = q.stab[FCC_S_OCP];
    assign tsd  = q.stab[FCC_S_TSD];
    assign peak = q.stab[FCC_S_PK];
    assign zc   = q.stab[FCC_S_ZC];

    // ========================================================================
    // charge sequencer
    // ========================================================================
    always_comb begin
        d       = q;
        d.meta  = {zero_detect, peak_detect, thermal_detect,
                   overcurrent_detect, full_detect, charge_request};
        d.stab  = q.meta;
        d.fmeta = {flash_permit, flash_fire};
        d.fstab = q.fmeta;
        case (q.mode)
            FCC_IDLE: begin
                d.sw  = 1'b0;
                d.cnt = '0;
                if (req) begin // RL1
                    d.mode = tsd ? FCC_FAULT : FCC_ARM; // RL6
                end
            end
            FCC_ARM: begin
                if (!req) begin
                    d.mode = FCC_IDLE; // RL18
                end else if (tsd) begin
                    d.mode = FCC_FAULT; // RL17
                end else if (q.cnt == ARM_LAST) begin
                    // delay filters short glitches on the request pin
                    d.mode = FCC_CHARGE; // RL2
                    d.sw   = 1'b1;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            FCC_CHARGE: begin
                // forced stop outranks every other stop cause
                if (!req) begin
                    d.mode = FCC_IDLE; // RL3
                    d.sw   = 1'b0;
                end else if ((overcurrent_trip && q.sw) || tsd) begin
                    d.mode = FCC_FAULT; // RL5 RL14
                    d.sw   = 1'b0;
                end else if (full) begin
                    d.mode = FCC_DONE; // RL4 RL10
                    d.sw   = 1'b0; // RL16
                end else if (peak) begin
                    d.sw = 1'b0; // RL11
                end else if (zc) begin
                    d.sw = 1'b1;
                end
            end
            FCC_DONE: begin
                d.sw = 1'b0;
                if (!req) begin
                    d.mode = FCC_IDLE; // RL9
                end
            end
            FCC_FAULT: begin
                d.sw = 1'b0;
                // trip holds until the host drops request and it has cleared
                if (!req && !overcurrent_trip && !tsd) begin
                    d.mode = FCC_IDLE; // RL17
                end
            end
            default: begin
                d.mode = FCC_IDLE;
                d.sw   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q.meta  <= '0;
            q.stab  <= '0;
            q.fmeta <= 2'h0;
            q.fstab <= 2'h0;
            q.mode  <= FCC_IDLE;
            q.cnt   <= '0;
            q.sw    <= FCC_SW_RST;
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    assign primary_switch    = q.sw;
    assign charge_enable_int = (q.mode == FCC_CHARGE);
    assign fault_latched     = (q.mode == FCC_FAULT);
    // open drain: only ever pulls low, never drives high
    assign charge_done_n_o   = 1'b0; // RL7
    // state decode, so the pin releases on the same edge the state leaves done
    assign charge_done_n_oe  = (q.mode == FCC_DONE); // RL8

    assign gif.fire   = q.fstab[0];
    assign gif.permit = q.fstab[1];
    assign gate_drive_out = gif.gate; // RL12

    fcc_gate u_gate (
        .clk        (clk),
        .rst_sync_n (rst_sync_n),
        .gif        (gif)
    );

    // ========================================================================
    // checks
    // ========================================================================
    logic [1:0] age_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    property p_start_req;
        (q.mode == FCC_IDLE && !req) |=> (q.mode == FCC_IDLE);
    endproperty
    a_start_req: assert property (p_start_req) else $error("left idle without request"); // RL1

    property p_en_delay;
        $rose(charge_enable_int) |-> $past(q.mode) == FCC_ARM && $past(q.cnt) == ARM_LAST;
    endproperty
    a_en_delay: assert property (p_en_delay) else $error("enable rose without full delay"); // RL2

    property p_forced;
        (charge_enable_int && !req) |=> !charge_enable_int && !primary_switch;
    endproperty
    a_forced: assert property (p_forced) else $error("forced stop not immediate"); // RL3

    property p_full_stop;
        (charge_enable_int && req && !overcurrent_trip && !tsd && full) |=> charge_done_n_oe && !primary_switch;
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("full charge did not stop"); // RL4

    property p_ocp_stop;
        (charge_enable_int && req && overcurrent_trip && primary_switch) |=> fault_latched && !primary_switch;
    endproperty
    a_ocp_stop: assert property (p_ocp_stop) else $error("overcurrent did not latch off"); // RL5

    property p_restart;
        (q.mode == FCC_IDLE && req && !tsd) |=> (q.mode == FCC_ARM) && (q.cnt == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("restart not accepted"); // RL6

    property p_open_drain;
        charge_done_n_oe |-> !charge_done_n_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("done pin driven high"); // RL7

    property p_released;
        (charge_enable_int || fault_latched || q.mode == FCC_ARM) |-> !charge_done_n_oe;
    endproperty
    a_released: assert property (p_released) else $error("done pin low while busy"); // RL8

    property p_done_hold;
        (charge_done_n_oe && req) |=> charge_done_n_oe;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done cleared without request low"); // RL9

    property p_done_lat;
        (age_q == 2'h3 && $rose(charge_done_n_oe)) |-> $past(full_detect, LAT);
    endproperty
    a_done_lat: assert property (p_done_lat) else $error("done not caused by full detect"); // RL10

    property p_peak_off;
        (charge_enable_int && req && !overcurrent_trip && !tsd && !full && peak) |=> !primary_switch;
    endproperty
    a_peak_off: assert property (p_peak_off) else $error("switch stayed on past peak"); // RL11

    property p_gate_lat;
        (age_q == 2'h3) |-> gate_drive_out == ($past(flash_fire, LAT) && $past(flash_permit, LAT));
    endproperty
    a_gate_lat: assert property (p_gate_lat) else $error("gate does not follow inputs"); // RL12

    property p_no_done_trip;
        (fault_latched && req) |=> !charge_done_n_oe;
    endproperty
    a_no_done_trip: assert property (p_no_done_trip) else $error("done after trip"); // RL14

    property p_done_off;
        $rose(charge_done_n_oe) |-> !charge_enable_int && !primary_switch;
    endproperty
    a_done_off: assert property (p_done_off) else $error("enable kept after completion"); // RL16

    property p_trip_hold;
        (fault_latched && (req || overcurrent_trip || tsd)) |=> fault_latched;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip released early"); // RL17

    property p_abandon;
        (q.mode == FCC_ARM && !req) |=> (q.mode == FCC_IDLE) ##1 (q.cnt == '0);
    endproperty
    a_abandon: assert property (p_abandon) else $error("pending start not abandoned"); // RL18

    c_charge: cover property ($rose(charge_enable_int));
    c_done:   cover property ($rose(charge_done_n_oe));
    c_fault:  cover property ($rose(fault_latched));
    c_gate:   cover property ($rose(gate_drive_out));

endmodule : fcc_top

// file: rtl/fcc_pkg.sv
// flash charge control: shared constants, timing counts and mode encoding
// assumes a single 10 MHz clock; all inputs from pins or analogue comparators
package fcc_pkg;

    // ========================================================================
    // clock and timing
    // ========================================================================
    localparam int unsigned FCC_CLK_PERIOD_NS = 100;
    // enable delay after the request edge: typical and longest
    localparam int unsigned FCC_EN_DLY_NS     = 50000;
    localparam int unsigned FCC_EN_MAX_NS     = 150000;
    localparam int unsigned FCC_EN_DLY_CYC    = (FCC_EN_DLY_NS + FCC_CLK_PERIOD_NS - 1) / FCC_CLK_PERIOD_NS;
    localparam int unsigned FCC_EN_MAX_CYC    = FCC_EN_MAX_NS / FCC_CLK_PERIOD_NS;
    // comparator to output delays; each floors at one cycle
    localparam int unsigned FCC_GATE_DLY_NS   = 25;
    localparam int unsigned FCC_PEAK_OFF_NS   = 75;
    localparam int unsigned FCC_DONE_DLY_NS   = 200;
    localparam int unsigned FCC_GATE_DLY_CYC  = (FCC_GATE_DLY_NS < FCC_CLK_PERIOD_NS) ? 1 :
                                                FCC_GATE_DLY_NS / FCC_CLK_PERIOD_NS;
    localparam int unsigned FCC_PEAK_OFF_CYC  = (FCC_PEAK_OFF_NS < FCC_CLK_PERIOD_NS) ? 1 :
                                                FCC_PEAK_OFF_NS / FCC_CLK_PERIOD_NS;
    localparam int unsigned FCC_DONE_DLY_CYC  = (FCC_DONE_DLY_NS < FCC_CLK_PERIOD_NS) ? 1 :
                                                FCC_DONE_DLY_NS / FCC_CLK_PERIOD_NS;
    localparam int unsigned FCC_CNT_W         = 12;

    // ========================================================================
    // synchroniser bit positions
    // ========================================================================
    localparam int unsigned FCC_NSYNC = 6;
    localparam int unsigned FCC_S_REQ = 0;
    localparam int unsigned FCC_S_FUL = 1;
    localparam int unsigned FCC_S_OCP = 2;
    localparam int unsigned FCC_S_TSD = 3;
    localparam int unsigned FCC_S_PK  = 4;
    localparam int unsigned FCC_S_ZC  = 5;

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic FCC_SW_RST   = 1'b0;
    localparam logic FCC_GATE_RST = 1'b0;

    typedef enum logic [2:0] {
        FCC_IDLE,
        FCC_ARM,
        FCC_CHARGE,
        FCC_DONE,
        FCC_FAULT
    } fcc_mode_t;

endpackage : fcc_pkg

// file: rtl/fcc_if.sv
// flash charge control: link between charge control and gate driver
// assumes both ends run on the same clock
interface fcc_if;
    logic fire;
    logic permit;
    logic gate;

    modport ctl (output fire, output permit, input gate);
    modport drv (input fire, input permit, output gate);
endinterface : fcc_if

// file: rtl/fcc_gate.sv
// flash charge control: strobe gate driver stage
// assumes fire and permit are already synchronised to clk
module fcc_gate import fcc_pkg::*; (
    input  wire logic clk,
    input  wire logic rst_sync_n,
    fcc_if.drv        gif
);

    typedef struct packed {
        logic gate;
    } fcc_gate_st_t;

    fcc_gate_st_t q;
    fcc_gate_st_t d;

    // ========================================================================
    // gate logic
    // ========================================================================
    always_comb begin
        d      = q;
        d.gate = gif.fire & gif.permit; // RL13
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q.gate <= FCC_GATE_RST;
        end else begin
            q <= d; // RL12
        end
    end

    assign gif.gate = q.gate;

    // ========================================================================
    // checks
    // ========================================================================
    property p_gate_and;
        @(posedge clk) disable iff (!rst_sync_n)
        (!gif.fire || !gif.permit) |=> !gif.gate;
    endproperty
    a_gate_and: assert property (p_gate_and) else $error("gate on with an input low"); // RL13

    property p_gate_on;
        @(posedge clk) disable iff (!rst_sync_n)
        (gif.fire && gif.permit) |=> gif.gate;
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("gate not on with both inputs high"); // RL13

endmodule : fcc_gate

// file: test/fcc_host.sv
// flash charge control: host controller model on the far side
// assumes the bench calls set_req only at the falling clock edge
module fcc_host #(
    parameter int MAX_CHG = 30
) (
    input  wire logic clk,
    input  wire logic done_o,
    input  wire logic done_oe,
    output logic      charge_request,
    output logic      done_pin,
    output logic      trip_seen
);
    timeunit 1ns;
    timeprecision 1ns;

    int wait_cyc = 0;

    // ========================================================================
    // open-drain line with pull-up
    // ========================================================================
    // released line reads high, never the last driven value
    assign done_pin = done_oe ? done_o : 1'b1;

    initial charge_request = 1'b0;

    // ========================================================================
    // request-to-done timer
    // ========================================================================
    // a trip never shows on the pin, so only elapsed time reveals it
    always @(posedge clk) begin
        if (!charge_request)
            wait_cyc <= 0;
        else if (done_pin)
            wait_cyc <= wait_cyc + 1;
    end
    assign trip_seen = charge_request && (wait_cyc > MAX_CHG);

    task automatic set_req(input logic v);
        charge_request = v;
    endtask : set_req
endmodule : fcc_host

// file: test/fcc_top_test.sv
// flash charge control: self-checking bench for fcc_top
// assumes the host model in fcc_host.sv; short arm delay for run time
module fcc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fcc_pkg::*;

    localparam int unsigned ARM = 4;
    logic clk  = 1'b0;
    logic rst_n;
    logic full_d, ocd, tsd, pk, zc;
    logic fire, permit;
    logic req, sw, en, d_o, d_oe, gate, fault, pin, trip;
    int   bad_count = 0;
    int   samples_checked = 0;

    always #50 clk = ~clk;

    fcc_top #(.ARM_CYC(ARM)) fcc_top_inst (
        .clk(clk), .rst_n(rst_n), .charge_request(req), .full_detect(full_d),
        .overcurrent_detect(ocd), .thermal_detect(tsd), .peak_detect(pk),
        .zero_detect(zc), .flash_fire(fire), .flash_permit(permit),
        .primary_switch(sw), .charge_enable_int(en), .charge_done_n_o(d_o),
        .charge_done_n_oe(d_oe), .gate_drive_out(gate), .fault_latched(fault));

    fcc_host fcc_host_inst (
        .clk(clk), .done_o(d_o), .done_oe(d_oe), .charge_request(req),
        .done_pin(pin), .trip_seen(trip));

    // ========================================================================
    // helpers
    // ========================================================================
    task automatic chk(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // enable shows at the (ARM + 3)rd falling edge after the request
    task automatic start;
        fcc_host_inst.set_req(1'b1);
        cyc(ARM + 2);
        chk(en, 1'b0, "enable early");
        cyc(1);
        chk(en, 1'b1, "enable rise");
        chk(sw, 1'b1, "switch on");
        chk(pin, 1'b1, "done while charging");
    endtask : start

    task automatic stop;
        fcc_host_inst.set_req(1'b0);
        cyc(4);
    endtask : stop

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic t_start_stop;
        start();
        fcc_host_inst.set_req(1'b0);
        cyc(2);
        chk(en, 1'b1, "stop too early");
        cyc(1);
        chk(en, 1'b0, "forced stop");
        chk(sw, 1'b0, "switch after stop");
        start();
        stop();
        $display("test start_stop done");
    endtask : t_start_stop

    task automatic t_abandon;
        fcc_host_inst.set_req(1'b1);
        cyc(3);
        fcc_host_inst.set_req(1'b0);
        cyc(ARM + 6);
        chk(en, 1'b0, "abandoned start");
        start();
        stop();
        $display("test abandon done");
    endtask : t_abandon

    task automatic t_peak;
        start();
        pk = 1'b1;
        cyc(2);
        chk(sw, 1'b1, "peak off early");
        cyc(1);
        chk(sw, 1'b0, "peak off");
        chk(en, 1'b1, "peak keeps enable");
        // overcurrent is only honoured while the switch is on
        ocd = 1'b1;
        cyc(3);
        chk(fault, 1'b0, "trip with switch off");
        ocd = 1'b0;
        pk = 1'b0;
        zc = 1'b1;
        cyc(3);
        chk(sw, 1'b1, "zero on");
        zc = 1'b0;
        stop();
        $display("test peak done");
    endtask : t_peak

    task automatic t_full;
        start();
        full_d = 1'b1;
        cyc(2);
        chk(pin, 1'b1, "done early");
        cyc(1);
        chk(pin, 1'b0, "done low");
        chk(en, 1'b0, "enable off at full");
        chk(sw, 1'b0, "switch off at full");
        full_d = 1'b0;
        cyc(10);
        chk(pin, 1'b0, "done held");
        chk(trip, 1'b0, "host sees no trip");
        fcc_host_inst.set_req(1'b0);
        cyc(3);
        chk(pin, 1'b1, "done cleared");
        cyc(1);
        $display("test full done");
    endtask : t_full

    task automatic t_ocp;
        start();
        ocd = 1'b1;
        cyc(3);
        chk(fault, 1'b1, "trip latch");
        chk(sw, 1'b0, "switch off at trip");
        ocd = 1'b0;
        full_d = 1'b1;
        cyc(40);
        chk(pin, 1'b1, "done after trip");
        chk(fault, 1'b1, "trip held");
        chk(trip, 1'b1, "host sees trip");
        full_d = 1'b0;
        fcc_host_inst.set_req(1'b0);
        cyc(3);
        chk(fault, 1'b0, "trip cleared");
        cyc(1);
        $display("test ocp done");
    endtask : t_ocp

    task automatic t_thermal;
        tsd = 1'b1;
        fcc_host_inst.set_req(1'b1);
        cyc(8);
        chk(fault, 1'b1, "thermal latch");
        chk(en, 1'b0, "no enable in trip");
        tsd = 1'b0;
        cyc(5);
        chk(fault, 1'b1, "thermal held");
        stop();
        chk(fault, 1'b0, "thermal cleared");
        $display("test thermal done");
    endtask : t_thermal

    task automatic t_gate;
        logic [1:0] seq [6];
        logic       prev;
        seq  = '{2'h3, 2'h1, 2'h3, 2'h2, 2'h0, 2'h3};
        prev = 1'b0;
        for (int i = 0; i < 6; i++) begin
            fire   = seq[i][1];
            permit = seq[i][0];
            cyc(2);
            chk(gate, prev, "gate early");
            cyc(1);
            chk(gate, &seq[i], "gate level");
            prev = &seq[i];
        end
        fire   = 1'b0;
        permit = 1'b0;
        cyc(3);
        $display("test gate done");
    endtask : t_gate

    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        rst_n  = 1'b0;
        full_d = 1'b0;
        ocd    = 1'b0;
        tsd    = 1'b0;
        pk     = 1'b0;
        zc     = 1'b0;
        fire   = 1'b0;
        permit = 1'b0;
        cyc(20);
        chk(sw, 1'b0, "reset switch");
        chk(gate, 1'b0, "reset gate");
        chk(pin, 1'b1, "reset done pin");
        rst_n = 1'b1;
        cyc(4);
        chk(en, 1'b0, "idle enable");
        chk(fault, 1'b0, "idle fault");
        t_start_stop();
        t_abandon();
        t_peak();
        t_full();
        t_ocp();
        t_thermal();
        t_gate();
        conclude();
    end
endmodule : fcc_top_test
